// ===== core/qdw_pkg.sv
package qdw_pkg;
    // Address byte: fixed top five bits, then two pin bits, then direction
    localparam logic [4:0] DEV_ADDR_TOP = 5'h13;
    // High-speed entry code: top five bits, low three are don't care
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam logic [7:0] HS_CODE_BYTE = 8'h08;
    // Control byte fields
    localparam int CTRL_PTYPE_BIT = 0;
    localparam int CTRL_CHAN_LSB = 1;
    localparam int CTRL_LOAD_LSB = 4;
    // Top two bits of a byte carry power-down mode or D1..D0
    localparam int BYTE_TOP_LSB = 6;
    // Channel register layout: power-down on top, data below
    localparam int SLOT_W = 12;
    localparam int DATA_W = 10;
    localparam int CHANNELS = 4;
    // Bits per byte and the acknowledge slot index
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // Controller registers, byte addresses
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h4;
    localparam logic [3:0] REG_CMD = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;
    // Configuration register fields
    localparam int CFG_W = 9;
    localparam int CFG_PINS_LSB = 0;
    localparam int CFG_CHAN_LSB = 2;
    localparam int CFG_LOAD_LSB = 4;
    localparam int CFG_PTYPE_BIT = 6;
    localparam int CFG_HS_BIT = 7;
    localparam int CFG_KEEP_BIT = 8;
    localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 10'h000;
    localparam int CMD_GO_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing: system clock period and serial clock period in ns
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    // Receiver states
    typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_CTRL, DS_MSB, DS_LSB, DS_SKIP} qdw_dev_state_e;
    // Controller sequencer states
    typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} qdw_mst_state_e;
endpackage

// ===== core/qdw_link_if.sv
`timescale 1ns/1ns
interface qdw_link_if;
    // Controller pins: enable high pulls the wire low
    logic m_scl_out;
    logic m_scl_oe;
    logic m_sda_out;
    logic m_sda_oe;
    // Receiver data pin
    logic d_sda_out;
    logic d_sda_oe;
    // Resolved wired-AND levels with pull-up
    logic scl;
    logic sda;
    assign scl = !(m_scl_oe && !m_scl_out);
    assign sda = !((m_sda_oe && !m_sda_out) || (d_sda_oe && !d_sda_out));
    modport master (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
    modport device (output d_sda_out, d_sda_oe, input scl, sda);
endinterface

// ===== core/qdw_master.sv
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module qdw_master import qdw_pkg::*; #(
    parameter int QTR = QTR_CYC
) (
    // System
    input wire logic clock,
    input wire logic reset_n,
    // AXI4-Lite write
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Serial link
    qdw_link_if.master link
);
    typedef struct packed {
        logic aw_got;
        logic [3:0] aw_addr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [CFG_W-1:0] cfg;
        logic [DATA_W-1:0] data;
        logic [CFG_W-1:0] snap_cfg;
        logic [DATA_W-1:0] snap_data;
        logic busy;
        logic nack;
        qdw_mst_state_e mst;
        logic [1:0] q;
        logic [7:0] div;
        logic [3:0] bitn;
        logic [2:0] k;
        logic [7:0] sh;
        logic acked;
        logic scl_low;
        logic sda_low;
        logic [2:0] sda_sy;
        logic sda_f;
    } qdw_mst_s;

    qdw_mst_s s_reg;
    qdw_mst_s s_next;
    logic go;
    logic tick;
    logic [31:0] merged;

    // Byte k of a write: code, address, control, high byte, low byte
    function automatic logic [7:0] byte_at(logic [2:0] k, logic [CFG_W-1:0] c, logic [DATA_W-1:0] d);
        case (k)
            3'h0: byte_at = HS_CODE_BYTE;
            3'h1: byte_at = {DEV_ADDR_TOP, c[CFG_PINS_LSB+:2], 1'b0};
            3'h2: byte_at = {2'b00, c[CFG_LOAD_LSB+:2], 1'b0, c[CFG_CHAN_LSB+:2], c[CFG_PTYPE_BIT]};
            3'h3: byte_at = c[CFG_PTYPE_BIT] ? {d[1:0], 6'h00} : d[DATA_W-1:2];
            3'h4: byte_at = c[CFG_PTYPE_BIT] ? 8'h00 : {d[1:0], 6'h00};
            default: byte_at = 8'h00;
        endcase
    endfunction

    // Ready outputs are combinational; valid and data outputs come from flops
    assign awready = !s_reg.aw_got && !s_reg.bvalid;
    assign wready = !s_reg.w_got && !s_reg.bvalid;
    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign arready = !s_reg.rvalid;
    assign rvalid = s_reg.rvalid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;
    // Open-drain: only ever pull low
    assign link.m_scl_out = 1'b0;
    assign link.m_scl_oe = s_reg.scl_low;
    assign link.m_sda_out = 1'b0;
    assign link.m_sda_oe = s_reg.sda_low;

    // Bus slave and bit sequencer
    always_comb begin
        s_next = s_reg;
        go = 1'b0;
        merged = 32'h0000_0000;
        if (awvalid && awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_next.w_got = 1'b1;
            s_next.wdata = wdata;
            s_next.wstrb = wstrb;
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        // Both halves held: commit the write, answer next edge
        if (s_reg.aw_got && s_reg.w_got) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            merged = {16'h0000, 7'h00, s_reg.cfg};
            if (s_reg.aw_addr == REG_DATA) begin
                merged = {16'h0000, 6'h00, s_reg.data};
            end
            for (int b = 0; b < 2; b++) begin
                if (s_reg.wstrb[b]) begin
                    merged[8*b+:8] = s_reg.wdata[8*b+:8];
                end
            end
            case (s_reg.aw_addr)
                REG_CFG: s_next.cfg = merged[CFG_W-1:0];
                REG_DATA: s_next.data = merged[DATA_W-1:0];
                // A start while busy is dropped
                REG_CMD: go = s_reg.wstrb[0] && s_reg.wdata[CMD_GO_BIT] && !s_reg.busy;
                REG_STATUS: ;
                default: s_next.bresp = RESP_SLVERR;
            endcase
        end
        // Reads answer one edge after acceptance
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            case (araddr)
                REG_CFG: s_next.rdata = {23'h0, s_reg.cfg};
                REG_DATA: s_next.rdata = {22'h0, s_reg.data};
                REG_CMD: s_next.rdata = 32'h0000_0000;
                REG_STATUS: s_next.rdata = {30'h0, s_reg.nack, s_reg.busy};
                default: begin
                    s_next.rdata = 32'h0000_0000;
                    s_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        // Returned data line, three flops, change on agreement
        s_next.sda_sy = {s_reg.sda_sy[1:0], link.sda};
        if (s_reg.sda_sy[1] == s_reg.sda_sy[2]) begin
            s_next.sda_f = s_reg.sda_sy[2];
        end
        // Quarter-bit divider
        tick = (s_reg.div == 8'(QTR - 1));
        s_next.div = tick ? 8'h00 : s_reg.div + 8'h01;
        if (go) begin
            // Snapshot so register writes cannot bend a running frame
            s_next.snap_cfg = s_reg.cfg;
            s_next.snap_data = s_reg.data;
            s_next.mst = MS_START;
            s_next.q = 2'h0;
            s_next.div = 8'h00;
            s_next.k = s_reg.cfg[CFG_HS_BIT] ? 3'h0 : 3'h1;
            s_next.busy = 1'b1;
            s_next.nack = 1'b0;
        end else if (tick && s_reg.mst != MS_IDLE) begin
            s_next.q = s_reg.q + 2'h1;
            case (s_reg.mst)
                // Start or repeated start: release data, raise clock, pull data, lower clock
                MS_START: begin
                    case (s_reg.q)
                        2'h0: s_next.sda_low = 1'b0;
                        2'h1: s_next.scl_low = 1'b0;
                        2'h2: s_next.sda_low = 1'b1;
                        default: begin
                            s_next.scl_low = 1'b1;
                            s_next.mst = MS_BIT;
                            s_next.bitn = 4'h0;
                            s_next.sh = byte_at(s_reg.k, s_reg.snap_cfg, s_reg.snap_data);
                        end
                    endcase
                end
                MS_BIT: begin
                    case (s_reg.q)
                        2'h0: s_next.sda_low = (s_reg.bitn == ACK_SLOT) ? 1'b0 : !s_reg.sh[7];
                        2'h1: s_next.scl_low = 1'b0;
                        2'h2: s_next.acked = !s_reg.sda_f;
                        default: begin
                            s_next.scl_low = 1'b1;
                            s_next.sh = {s_reg.sh[6:0], 1'b0};
                            s_next.bitn = s_reg.bitn + 4'h1;
                            if (s_reg.bitn == ACK_SLOT) begin
                                s_next.bitn = 4'h0;
                                s_next.k = s_reg.k + 3'h1;
                                s_next.sh = byte_at(s_reg.k + 3'h1, s_reg.snap_cfg, s_reg.snap_data);
                                if (s_reg.k == 3'h0) begin
                                    s_next.mst = MS_START;
                                end else if (!s_reg.acked) begin
                                    s_next.nack = 1'b1;
                                    s_next.mst = MS_STOP;
                                end else if (s_reg.k == 3'h4) begin
                                    // Keep the bus: hold clock low, next start is a repeat
                                    s_next.mst = s_reg.snap_cfg[CFG_KEEP_BIT] ? MS_IDLE : MS_STOP;
                                    s_next.busy = !s_reg.snap_cfg[CFG_KEEP_BIT];
                                end
                            end
                        end
                    endcase
                end
                MS_STOP: begin
                    case (s_reg.q)
                        2'h0: s_next.sda_low = 1'b1;
                        2'h1: s_next.scl_low = 1'b0;
                        2'h2: s_next.sda_low = 1'b0;
                        default: begin
                            s_next.mst = MS_IDLE;
                            s_next.busy = 1'b0;
                        end
                    endcase
                end
                default: s_next.mst = MS_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// ===== core/qdw_device.sv
`timescale 1ns/1ns
// How it works
// - Write opens with address, direction bit clear
// - Control byte sets load mode and channel
// - Control bit zero picks data or power-down
// - Data pairs repeat until stop or restart
// - Power-down mode takes exactly two bytes
// - High byte D9..D2, low byte D1..D0 on top
// - Acknowledge address, control and each payload byte
// - Never acknowledge the high-speed entry code
// - After entry code, restart then normal write
// - Controller prefers restart over stop between writes
// - Apply write at falling edge ending ack
// - Power-down bits are top two of byte
// - Each channel: 12-bit temporary and output registers
module qdw_device import qdw_pkg::*; #(
    parameter int NUM_CH = CHANNELS
) (
    // Link clock and reset
    input wire logic link_clock,
    input wire logic reset_n,
    // Address select straps
    input wire logic addr_pin_hi,
    input wire logic addr_pin_lo,
    // Serial link
    qdw_link_if.device link,
    // Channel registers
    output logic [NUM_CH-1:0][SLOT_W-1:0] channel_temp_reg,
    output logic [NUM_CH-1:0][SLOT_W-1:0] channel_output_reg,
    // Update report
    output logic [1:0] load_mode,
    output logic update_pulse,
    output logic [1:0] update_channel,
    output logic addressed
);
    typedef struct packed {
        // Synchronisers, oldest bit on top
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic [2:0] pin_hi_sy;
        logic [2:0] pin_lo_sy;
        // Filtered levels
        logic scl_f;
        logic sda_f;
        logic [1:0] pins_f;
        // Byte receiver
        qdw_dev_state_e st;
        qdw_dev_state_e st_after;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic ack_ph;
        logic sda_low;
        // Received fields
        logic [7:0] ctrl;
        logic [7:0] msb;
        logic upd_pend;
        logic [SLOT_W-1:0] staged;
        // Channel storage
        logic [NUM_CH-1:0][SLOT_W-1:0] temp;
        logic [NUM_CH-1:0][SLOT_W-1:0] outr;
        // Update report
        logic upd;
        logic [1:0] upd_ch;
    } qdw_dev_s;

    qdw_dev_s s_reg;
    qdw_dev_s s_next;
    logic scl_new;
    logic sda_new;
    logic rise;
    logic fall;
    logic start_seen;
    logic stop_seen;
    logic [1:0] ch;

    // Outputs straight from flops; addressed is decoded from the state
    assign channel_temp_reg = s_reg.temp;
    assign channel_output_reg = s_reg.outr;
    assign load_mode = s_reg.ctrl[CTRL_LOAD_LSB+:2];
    assign update_pulse = s_reg.upd;
    assign update_channel = s_reg.upd_ch;
    assign addressed = (s_reg.st == DS_CTRL) || (s_reg.st == DS_MSB) || (s_reg.st == DS_LSB);
    // Never drive high; the ack is a pull low
    assign link.d_sda_out = 1'b0;
    assign link.d_sda_oe = s_reg.sda_low;

    // Receiver: filter, detect conditions, shift bytes, answer acks
    always_comb begin
        s_next = s_reg;
        s_next.upd = 1'b0;
        ch = s_reg.ctrl[CTRL_CHAN_LSB+:2];
        // Three flops per pin; first flop feeds only the second
        s_next.scl_sy = {s_reg.scl_sy[1:0], link.scl};
        s_next.sda_sy = {s_reg.sda_sy[1:0], link.sda};
        s_next.pin_hi_sy = {s_reg.pin_hi_sy[1:0], addr_pin_hi};
        s_next.pin_lo_sy = {s_reg.pin_lo_sy[1:0], addr_pin_lo};
        // A change counts once the later two flops agree
        scl_new = (s_reg.scl_sy[1] == s_reg.scl_sy[2]) ? s_reg.scl_sy[2] : s_reg.scl_f;
        sda_new = (s_reg.sda_sy[1] == s_reg.sda_sy[2]) ? s_reg.sda_sy[2] : s_reg.sda_f;
        if (s_reg.pin_hi_sy[1] == s_reg.pin_hi_sy[2]) begin
            s_next.pins_f[1] = s_reg.pin_hi_sy[2];
        end
        if (s_reg.pin_lo_sy[1] == s_reg.pin_lo_sy[2]) begin
            s_next.pins_f[0] = s_reg.pin_lo_sy[2];
        end
        s_next.scl_f = scl_new;
        s_next.sda_f = sda_new;
        // Edges and bus conditions on the filtered levels
        rise = !s_reg.scl_f && scl_new;
        fall = s_reg.scl_f && !scl_new;
        start_seen = s_reg.scl_f && scl_new && s_reg.sda_f && !sda_new;
        stop_seen = s_reg.scl_f && scl_new && !s_reg.sda_f && sda_new;
        if (start_seen) begin
            // Start or repeat: back to addressing, ends any data stream
            s_next.st = DS_ADDR;
            s_next.cnt = 4'h0;
            s_next.ack_ph = 1'b0;
            s_next.sda_low = 1'b0;
            s_next.upd_pend = 1'b0;
        end else if (stop_seen) begin
            // Stop ends the stream; a half pair is dropped
            s_next.st = DS_IDLE;
            s_next.cnt = 4'h0;
            s_next.ack_ph = 1'b0;
            s_next.sda_low = 1'b0;
            s_next.upd_pend = 1'b0;
        end else if (s_reg.st != DS_IDLE && s_reg.st != DS_SKIP) begin
            if (rise && !s_reg.ack_ph) begin
                // Sample data on the rising clock, MSB first
                s_next.sh = {s_reg.sh[6:0], sda_new};
                s_next.cnt = s_reg.cnt + 4'h1;
            end else if (fall && s_reg.ack_ph) begin
                // End of ack clock: release the line, move on
                s_next.ack_ph = 1'b0;
                s_next.sda_low = 1'b0;
                s_next.st = s_reg.st_after;
                if (s_reg.upd_pend) begin
                    // Temporary and output copies update together
                    s_next.temp[ch] = s_reg.staged;
                    s_next.outr[ch] = s_reg.staged;
                    s_next.upd = 1'b1;
                    s_next.upd_ch = ch;
                    s_next.upd_pend = 1'b0;
                end
            end else if (fall && s_reg.cnt == ACK_SLOT) begin
                // Eighth bit done: decide the answer for the ack clock
                s_next.cnt = 4'h0;
                s_next.ack_ph = 1'b1;
                s_next.sda_low = 1'b0;
                s_next.st_after = DS_SKIP;
                case (s_reg.st)
                    DS_ADDR: begin
                        if (s_reg.sh[7:3] == HS_CODE_TOP) begin
                            // Entry code: stay silent, wait for restart
                            s_next.sda_low = 1'b0;
                        end else if (s_reg.sh[7:1] == {DEV_ADDR_TOP, s_reg.pins_f} && !s_reg.sh[0]) begin
                            // Own address with write direction
                            s_next.sda_low = 1'b1;
                            s_next.st_after = DS_CTRL;
                        end
                    end
                    DS_CTRL: begin
                        // Whatever follows the address is the control byte
                        s_next.ctrl = s_reg.sh;
                        s_next.sda_low = 1'b1;
                        s_next.st_after = DS_MSB;
                    end
                    DS_MSB: begin
                        s_next.msb = s_reg.sh;
                        s_next.sda_low = 1'b1;
                        s_next.st_after = DS_LSB;
                    end
                    DS_LSB: begin
                        s_next.sda_low = 1'b1;
                        s_next.upd_pend = 1'b1;
                        if (s_reg.ctrl[CTRL_PTYPE_BIT]) begin
                            // Power-down: mode bits from first byte, data kept
                            s_next.staged = {s_reg.msb[BYTE_TOP_LSB+:2], s_reg.temp[ch][DATA_W-1:0]};
                            // Only two bytes; later ones are not acknowledged
                            s_next.st_after = DS_SKIP;
                        end else begin
                            // Data: normal operation, 10 bits from the pair
                            s_next.staged = {2'b00, s_reg.msb, s_reg.sh[7:BYTE_TOP_LSB]};
                            s_next.st_after = DS_MSB;
                        end
                    end
                    default: s_next.sda_low = 1'b0;
                endcase
            end
        end
    end

    // State register on the link clock
    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// ===== testbench/qdw_link_asserts.sv
`timescale 1ns/1ns
module qdw_link_asserts import qdw_pkg::*; (
    // Link clock and reset
    input wire logic link_clock,
    input wire logic reset_n,
    // Straps and wires
    input wire logic addr_pin_hi,
    input wire logic addr_pin_lo,
    input wire logic m_scl_out,
    input wire logic m_sda_out,
    input wire logic d_sda_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_sda_oe
);
    logic scl_q, sda_q, sel;
    logic [3:0] bit_cnt;
    logic [2:0] idx;
    logic [7:0] sh;
    // Raw wire edges; a quarter bit spans many link cycles
    wire logic rise = scl && !scl_q;
    wire logic start = scl && scl_q && sda_q && !sda;
    wire logic slot = rise && bit_cnt == ACK_SLOT;
    wire logic own = sh == {DEV_ADDR_TOP, addr_pin_hi, addr_pin_lo, 1'b0};
    default clocking cb @(posedge link_clock); endclocking
    default disable iff (!reset_n);
    // Byte monitor, restarted by every start or repeated start
    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sel <= 1'b0;
            bit_cnt <= 4'h0;
            idx <= 3'h0;
            sh <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start) begin
                bit_cnt <= 4'h0;
                idx <= 3'h0;
                sel <= 1'b0;
            end else if (slot) begin
                // Saturate so long streams do not wrap back to the address byte
                bit_cnt <= 4'h0;
                idx <= (idx == 3'h7) ? idx : idx + 3'h1;
                sel <= (idx == 3'h0) ? own : sel;
            end else if (rise) begin
                sh <= {sh[6:0], sda};
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end
    a_addr_ack: assert property (slot && idx == 3'h0 |-> d_sda_oe == own) else $error("address ack wrong");
    a_code_no_ack: assert property (slot && idx == 3'h0 && sh[7:3] == HS_CODE_TOP |-> !d_sda_oe)
        else $error("entry code acked");
    a_ctrl_ack: assert property (slot && idx == 3'h1 |-> d_sda_oe == sel) else $error("control ack wrong");
    a_data_ack: assert property (slot && (idx == 3'h2 || idx == 3'h3) |-> d_sda_oe == sel)
        else $error("payload ack wrong");
    a_quiet_bits: assert property (rise && bit_cnt != ACK_SLOT |-> !d_sda_oe) else $error("pull outside ack");
    a_ack_scl_low: assert property ($changed(d_sda_oe) |-> !scl) else $error("ack moved with clock high");
    a_ack_bounded: assert property ($rose(d_sda_oe) |-> d_sda_oe [*8] ##[1:400] !d_sda_oe)
        else $error("ack length wrong");
    a_open_drain: assert property (!m_scl_out && !m_sda_out) else $error("controller drives high");
    a_slot_open: assert property (slot |-> !m_sda_oe) else $error("controller holds ack slot");
    c_addr: cover property (slot && idx == 3'h0 && d_sda_oe);
    c_code: cover property (slot && idx == 3'h0 && sh[7:3] == HS_CODE_TOP);
    c_low: cover property (slot && idx == 3'h3 && d_sda_oe);
endmodule

// ===== testbench/quad_dac_i2c_write_receiver_test.sv
`timescale 1ns/1ns
module quad_dac_i2c_write_receiver_test import qdw_pkg::*;;
    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic reset_n = 1'b0;
    logic link_reset_n = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, update_pulse, addressed;
    logic addr_pin_hi = 1'b0, addr_pin_lo = 1'b0;
    logic [1:0] bresp, rresp, resp, load_mode, update_channel, last_chan, exp_load = 2'h0;
    logic [3:0][11:0] channel_temp_reg, channel_output_reg, exp_reg = '0;
    logic [8:0] cfg;
    logic [9:0] data;
    int bad_count = 0, comparisons = 0, cycles = 0, pulses = 0, exp_pulses = 0;
    int seed = 32'h78a9;
    qdw_link_if qdw_link_if_i ();
    // Short quarter bit keeps the run brief; still twelve and a half link cycles wide
    qdw_master #(.QTR(8)) qdw_master_i (.clock, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .link(qdw_link_if_i.master));
    qdw_device qdw_device_i (.link_clock, .reset_n(link_reset_n), .addr_pin_hi, .addr_pin_lo,
        .link(qdw_link_if_i.device), .channel_temp_reg, .channel_output_reg, .load_mode, .update_pulse,
        .update_channel, .addressed);
    qdw_link_asserts qdw_link_asserts_i (.link_clock, .reset_n(link_reset_n), .addr_pin_hi, .addr_pin_lo,
        .m_scl_out(qdw_link_if_i.m_scl_out), .m_sda_out(qdw_link_if_i.m_sda_out),
        .d_sda_oe(qdw_link_if_i.d_sda_oe), .scl(qdw_link_if_i.scl), .sda(qdw_link_if_i.sda),
        .m_sda_oe(qdw_link_if_i.m_sda_oe));
    always #50 clock = ~clock;
    initial begin
        #13;
        forever #32 link_clock = ~link_clock;
    end
    // Count channel updates and keep the last channel
    always @(posedge link_clock) begin
        if (update_pulse === 1'b1) begin
            pulses++;
            last_chan <= update_channel;
        end
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
        comparisons++;
    endtask
    // One bus write; each channel released at its own handshake
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Power-down keeps the data bits; a data write clears the mode bits
    function automatic logic [11:0] exp_slot(logic [8:0] c, logic [9:0] d, logic [11:0] o);
        exp_slot = c[6] ? {d[1:0], o[9:0]} : {2'b00, d};
    endfunction
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge link_clock);
        link_reset_n <= 1'b1;
        repeat (8) @(posedge link_clock);
        axi_read(4'h2, rd, resp);
        check("hole", 32'(resp), 32'(RESP_SLVERR));
        // Random frames; first two fixed: high-speed full scale, then power-down
        for (int i = 0; i < 20; i++) begin
            cfg = 9'($random(seed));
            data = 10'($random(seed));
            if (i == 0) cfg = 9'h0BC;
            if (i == 0) data = 10'h3FF;
            if (i == 1) cfg = 9'h04A;
            // Every fifth frame carries a strap mismatch
            addr_pin_hi <= cfg[1] ^ (i % 5 == 2);
            addr_pin_lo <= cfg[0];
            axi_write(REG_CFG, 32'(cfg), resp);
            axi_write(REG_DATA, 32'(data), resp);
            axi_write(REG_CMD, 32'h1, resp);
            check("go", 32'(resp), 32'(RESP_OKAY));
            do axi_read(REG_STATUS, rd, resp); while (rd[0] === 1'b1);
            repeat (10) @(posedge link_clock);
            if (i % 5 != 2) begin
                exp_pulses++;
                exp_load = cfg[5:4];
                exp_reg[cfg[3:2]] = exp_slot(cfg, data, exp_reg[cfg[3:2]]);
                check("channel", 32'(last_chan), 32'(cfg[3:2]));
            end
            check("nack", 32'(rd[1]), 32'(i % 5 == 2));
            check("load", 32'(load_mode), 32'(exp_load));
            check("updates", pulses, exp_pulses);
            check("stream open", 32'(addressed), 32'(cfg[8] && !cfg[6] && i % 5 != 2));
            for (int k = 0; k < 4; k++) begin
                check("temp", 32'(channel_temp_reg[k]), 32'(exp_reg[k]));
                check("output", 32'(channel_output_reg[k]), 32'(exp_reg[k]));
            end
        end
        give_verdict();
    end
endmodule
